// >>> rtl/aic_pkg.sv
// package for the analog input channel conditioning block
package aic_pkg;

	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_SIM = 8'h04;
	localparam logic [7:0] ADR_SUB = 8'h08;
	localparam logic [7:0] ADR_SHORT = 8'h0c;
	localparam logic [7:0] ADR_BREAK = 8'h10;
	localparam logic [7:0] ADR_LOWLIM = 8'h14;
	localparam logic [7:0] ADR_BEGPT = 8'h18;
	localparam logic [7:0] ADR_ENDPT = 8'h1c;
	localparam logic [7:0] ADR_UPLIM = 8'h20;
	localparam logic [7:0] ADR_BEGCUR = 8'h24;
	localparam logic [7:0] ADR_ENDCUR = 8'h28;
	localparam logic [7:0] ADR_STATUS = 8'h2c;
	localparam logic [7:0] ADR_VALUE = 8'h30;
	localparam logic [7:0] ADR_SCAN0 = 8'h40;
	localparam logic [7:0] ADR_SCAN1 = 8'h44;
	localparam logic [7:0] ADR_SCAN2 = 8'h48;

	// control field positions
	localparam int CTRL_SIM = 0;
	localparam int CTRL_FDET = 1;
	localparam int CTRL_ERR_LO = 2;
	localparam int CTRL_SIMINV = 4;
	localparam int CTRL_HART = 5;
	localparam int CTRL_SCAN = 6;
	localparam int CTRL_W = 7;
	// status field positions
	localparam int ST_SHORT = 0;
	localparam int ST_BREAK = 1;
	localparam int ST_INVALID = 2;
	localparam int ST_ACTIVE = 3;
	localparam int ST_FAULT = 4;

	localparam logic [1:0] ERR_CURRENT = 2'h0;
	localparam logic [1:0] ERR_SUBST = 2'h1;
	localparam logic [1:0] ERR_LAST = 2'h2;

	// reset values: currents in microamps, percent in hundredths
	localparam logic [6:0] RST_CTRL = 7'h42;
	localparam logic [15:0] RST_SHORT = 16'h5208;
	localparam logic [15:0] RST_BREAK = 16'h03e8;
	localparam logic [15:0] RST_LOWLIM = 16'h0000;
	localparam logic [15:0] RST_BEGPT = 16'h2710;
	localparam logic [15:0] RST_ENDPT = 16'hc350;
	localparam logic [15:0] RST_UPLIM = 16'hea60;
	localparam logic [15:0] RST_BEGCUR = 16'h0fa0;
	localparam logic [15:0] RST_ENDCUR = 16'h4e20;
	localparam logic signed [15:0] PCT_MIN = -16'sd2500;
	localparam logic signed [15:0] PCT_MAX = 16'sd12500;
	localparam logic signed [15:0] PCT_FULL = 16'sd10000;
	localparam int SCAN_N = 3;

	typedef enum logic [1:0] {HS_IDLE, HS_REQ} aic_hart_type;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} aic_wbreq_type;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} aic_wbrsp_type;

	typedef struct packed {
		aic_wbrsp_type wb;
		logic [6:0] ctrl;
		logic signed [15:0] simPct;
		logic signed [15:0] subPct;
		logic [15:0] shortTh;
		logic [15:0] breakTh;
		logic [15:0] lowLim;
		logic [15:0] begPt;
		logic [15:0] endPt;
		logic [15:0] upLim;
		logic [15:0] begCur;
		logic [15:0] endCur;
		logic [15:0] measCur;
		logic [15:0] lastValid;
		logic [15:0] value;
		logic invalid;
		logic isShort;
		logic isBreak;
		logic active;
		aic_hart_type hart;
		logic [1:0] hartCmd;
		logic hartReq;
		logic [SCAN_N-1:0][31:0] scanData;
	} aic_state_type;

endpackage

// >>> rtl/aic_channel.sv
// analog input channel: mode select, fault check, scaling, hart scan
//
// The register offsets and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
module aic_channel (
	input wire logic ref_clk,
	input wire logic srst,
	input wire aic_pkg::aic_wbreq_type wbReq,
	output aic_pkg::aic_wbrsp_type wbRsp,
	input wire logic [15:0] measCurrent,
	input wire logic measStrobe,
	input wire logic moduleActive,
	input wire logic hartAck,
	input wire logic [31:0] hartData,
	output logic [15:0] procValue,
	output logic procInvalid,
	output logic faultShort,
	output logic faultBreak,
	output logic channelActive,
	output logic hartReq,
	output logic [1:0] hartCmd
);

	////////////////////////////////////////////////////////////////////////
	// arithmetic helpers

	// y0 + (x-x0)*(y1-y0)/(x1-x0); zero span gives y0
	function automatic logic signed [31:0] interp(
		input logic signed [31:0] x,
		input logic signed [31:0] x0,
		input logic signed [31:0] x1,
		input logic signed [31:0] y0,
		input logic signed [31:0] y1
	);
		logic signed [47:0] num;
		logic signed [47:0] den;
		logic signed [47:0] res;
		num = 48'(x - x0) * 48'(y1 - y0);
		den = 48'(x1 - x0);
		if (den == 48'sh0)
			res = 48'(y0);
		else
			res = 48'(y0) + num / den;
		interp = 32'(res);
	endfunction

	// saturate at the limit points; the upper limit is checked last
	function automatic logic [15:0] saturate(
		input logic signed [31:0] v,
		input logic [15:0] lo,
		input logic [15:0] hi
	);
		logic signed [31:0] r;
		r = v;
		if (r < $signed({16'h0000, lo}))
			r = $signed({16'h0000, lo});
		if (r > $signed({16'h0000, hi}))
			r = $signed({16'h0000, hi});
		saturate = r[15:0];
	endfunction

	// percent of range to points; 0 % is start point, 100 % end point
	function automatic logic [15:0] pctToPoints(
		input logic signed [15:0] pct,
		input logic [15:0] b,
		input logic [15:0] e,
		input logic [15:0] lo,
		input logic [15:0] hi
	);
		logic signed [15:0] p;
		p = pct;
		if (p < aic_pkg::PCT_MIN)
			p = aic_pkg::PCT_MIN;
		if (p > aic_pkg::PCT_MAX)
			p = aic_pkg::PCT_MAX;
		pctToPoints = saturate(interp(32'(p), 32'sd0,
			32'(aic_pkg::PCT_FULL), $signed({16'h0000, b}),
			$signed({16'h0000, e})), lo, hi);
	endfunction

	// byte-lane merge of a write into a 16-bit register
	function automatic logic [15:0] merge16(
		input logic [15:0] old,
		input logic [31:0] wd,
		input logic [3:0] sel
	);
		merge16 = old;
		if (sel[0])
			merge16[7:0] = wd[7:0];
		if (sel[1])
			merge16[15:8] = wd[15:8];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// state

	aic_pkg::aic_state_type state_reg;
	aic_pkg::aic_state_type state_next;

	logic [15:0] measPts;
	logic [15:0] simPts;
	logic [15:0] subPts;
	logic isShortNow;
	logic isBreakNow;
	logic faultNow;
	logic access;
	logic [1:0] errMode;

	always_comb
	begin
		state_next = state_reg;
		errMode = state_reg.ctrl[aic_pkg::CTRL_ERR_LO +: 2];
		access = wbReq.cyc && wbReq.stb && !state_reg.wb.ack;

		// measured current into points across the configured span
		measPts = saturate(interp($signed({16'h0000, state_reg.measCur}),
			$signed({16'h0000, state_reg.begCur}),
			$signed({16'h0000, state_reg.endCur}),
			$signed({16'h0000, state_reg.begPt}),
			$signed({16'h0000, state_reg.endPt})),
			state_reg.lowLim, state_reg.upLim);
		simPts = pctToPoints(state_reg.simPct, state_reg.begPt,
			state_reg.endPt, state_reg.lowLim, state_reg.upLim);
		subPts = pctToPoints(state_reg.subPct, state_reg.begPt,
			state_reg.endPt, state_reg.lowLim, state_reg.upLim);

		// thresholds only count while line fault detection is on
		isShortNow = state_reg.ctrl[aic_pkg::CTRL_FDET] &&
			(state_reg.measCur > state_reg.shortTh);
		isBreakNow = state_reg.ctrl[aic_pkg::CTRL_FDET] &&
			(state_reg.measCur < state_reg.breakTh);
		faultNow = isShortNow || isBreakNow;
		state_next.isShort = isShortNow;
		state_next.isBreak = isBreakNow;

		if (measStrobe)
			state_next.measCur = measCurrent;

		// last-valid capture freezes as soon as a fault appears
		if (!faultNow)
			state_next.lastValid = measPts;

		if (state_reg.ctrl[aic_pkg::CTRL_SIM])
		begin
			// simulation overrides any error strategy
			state_next.value = simPts;
			state_next.invalid = state_reg.ctrl[aic_pkg::CTRL_SIMINV];
		end
		else if (faultNow)
		begin
			case (errMode)
				aic_pkg::ERR_SUBST:
				begin
					state_next.value = subPts;
					state_next.invalid = 1'b1;
				end
				aic_pkg::ERR_LAST:
				begin
					state_next.value = state_reg.lastValid;
					state_next.invalid = 1'b0;
				end
				default:
				begin
					state_next.value = measPts;
					state_next.invalid = 1'b0;
				end
			endcase
		end
		else
		begin
			state_next.value = measPts;
			state_next.invalid = 1'b0;
		end

		state_next.active = moduleActive;

		// hart scan walks the id, tag and variable requests in turn
		case (state_reg.hart)
			aic_pkg::HS_IDLE:
			begin
				state_next.hartReq = 1'b0;
				if (state_reg.ctrl[aic_pkg::CTRL_HART] &&
					state_reg.ctrl[aic_pkg::CTRL_SCAN])
				begin
					state_next.hartReq = 1'b1;
					state_next.hart = aic_pkg::HS_REQ;
				end
			end
			aic_pkg::HS_REQ:
			begin
				if (!state_reg.ctrl[aic_pkg::CTRL_HART] ||
					!state_reg.ctrl[aic_pkg::CTRL_SCAN])
				begin
					// abandon the request at once to free the hart time
					state_next.hartReq = 1'b0;
					state_next.hart = aic_pkg::HS_IDLE;
				end
				else if (hartAck)
				begin
					state_next.scanData[state_reg.hartCmd] = hartData;
					state_next.hartReq = 1'b0;
					state_next.hart = aic_pkg::HS_IDLE;
					if (state_reg.hartCmd == 2'(aic_pkg::SCAN_N - 1))
						state_next.hartCmd = 2'h0;
					else
						state_next.hartCmd = state_reg.hartCmd + 2'h1;
				end
			end
			default:
			begin
				state_next.hartReq = 1'b0;
				state_next.hart = aic_pkg::HS_IDLE;
			end
		endcase

		// wishbone slave: one wait state, ack for one cycle
		state_next.wb.ack = access;
		state_next.wb.dat = 32'h0;
		if (access && wbReq.we)
		begin
			case (wbReq.adr)
				aic_pkg::ADR_CTRL:
					if (wbReq.sel[0])
						state_next.ctrl = wbReq.dat[aic_pkg::CTRL_W-1:0];
				aic_pkg::ADR_SIM:
					state_next.simPct = merge16(state_reg.simPct,
						wbReq.dat, wbReq.sel);
				aic_pkg::ADR_SUB:
					state_next.subPct = merge16(state_reg.subPct,
						wbReq.dat, wbReq.sel);
				aic_pkg::ADR_SHORT:
					state_next.shortTh = merge16(state_reg.shortTh,
						wbReq.dat, wbReq.sel);
				aic_pkg::ADR_BREAK:
					state_next.breakTh = merge16(state_reg.breakTh,
						wbReq.dat, wbReq.sel);
				aic_pkg::ADR_LOWLIM:
					state_next.lowLim = merge16(state_reg.lowLim,
						wbReq.dat, wbReq.sel);
				aic_pkg::ADR_BEGPT:
					state_next.begPt = merge16(state_reg.begPt,
						wbReq.dat, wbReq.sel);
				aic_pkg::ADR_ENDPT:
					state_next.endPt = merge16(state_reg.endPt,
						wbReq.dat, wbReq.sel);
				aic_pkg::ADR_UPLIM:
					state_next.upLim = merge16(state_reg.upLim,
						wbReq.dat, wbReq.sel);
				aic_pkg::ADR_BEGCUR:
					state_next.begCur = merge16(state_reg.begCur,
						wbReq.dat, wbReq.sel);
				aic_pkg::ADR_ENDCUR:
					state_next.endCur = merge16(state_reg.endCur,
						wbReq.dat, wbReq.sel);
				default:
					state_next.wb.dat = 32'h0;
			endcase
		end
		else if (access)
		begin
			case (wbReq.adr)
				aic_pkg::ADR_CTRL:
					state_next.wb.dat = {25'h0, state_reg.ctrl};
				aic_pkg::ADR_SIM:
					state_next.wb.dat = {16'h0, state_reg.simPct};
				aic_pkg::ADR_SUB:
					state_next.wb.dat = {16'h0, state_reg.subPct};
				aic_pkg::ADR_SHORT:
					state_next.wb.dat = {16'h0, state_reg.shortTh};
				aic_pkg::ADR_BREAK:
					state_next.wb.dat = {16'h0, state_reg.breakTh};
				aic_pkg::ADR_LOWLIM:
					state_next.wb.dat = {16'h0, state_reg.lowLim};
				aic_pkg::ADR_BEGPT:
					state_next.wb.dat = {16'h0, state_reg.begPt};
				aic_pkg::ADR_ENDPT:
					state_next.wb.dat = {16'h0, state_reg.endPt};
				aic_pkg::ADR_UPLIM:
					state_next.wb.dat = {16'h0, state_reg.upLim};
				aic_pkg::ADR_BEGCUR:
					state_next.wb.dat = {16'h0, state_reg.begCur};
				aic_pkg::ADR_ENDCUR:
					state_next.wb.dat = {16'h0, state_reg.endCur};
				aic_pkg::ADR_STATUS:
				begin
					state_next.wb.dat[aic_pkg::ST_SHORT] = state_reg.isShort;
					state_next.wb.dat[aic_pkg::ST_BREAK] = state_reg.isBreak;
					state_next.wb.dat[aic_pkg::ST_INVALID] = state_reg.invalid;
					state_next.wb.dat[aic_pkg::ST_ACTIVE] = state_reg.active;
					state_next.wb.dat[aic_pkg::ST_FAULT] =
						state_reg.isShort || state_reg.isBreak;
				end
				aic_pkg::ADR_VALUE:
					state_next.wb.dat = {16'h0, state_reg.value};
				aic_pkg::ADR_SCAN0:
					state_next.wb.dat = state_reg.scanData[0];
				aic_pkg::ADR_SCAN1:
					state_next.wb.dat = state_reg.scanData[1];
				aic_pkg::ADR_SCAN2:
					state_next.wb.dat = state_reg.scanData[2];
				default:
					state_next.wb.dat = 32'h0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			state_reg <= '0;
			state_reg.ctrl <= aic_pkg::RST_CTRL;
			state_reg.shortTh <= aic_pkg::RST_SHORT;
			state_reg.breakTh <= aic_pkg::RST_BREAK;
			state_reg.lowLim <= aic_pkg::RST_LOWLIM;
			state_reg.begPt <= aic_pkg::RST_BEGPT;
			state_reg.endPt <= aic_pkg::RST_ENDPT;
			state_reg.upLim <= aic_pkg::RST_UPLIM;
			state_reg.begCur <= aic_pkg::RST_BEGCUR;
			state_reg.endCur <= aic_pkg::RST_ENDCUR;
			state_reg.hart <= aic_pkg::HS_IDLE;
		end
		else
			state_reg <= state_next;
	end

	assign wbRsp = state_reg.wb;
	assign procValue = state_reg.value;
	assign procInvalid = state_reg.invalid;
	assign faultShort = state_reg.isShort;
	assign faultBreak = state_reg.isBreak;
	assign channelActive = state_reg.active;
	assign hartReq = state_reg.hartReq;
	assign hartCmd = state_reg.hartCmd;

endmodule

// >>> bench/aic_channel_properties.sv
// concurrent checks on the channel ports
`timescale 1ns/1ps
module aic_channel_properties (
	input wire logic ref_clk,
	input wire logic srst,
	input wire aic_pkg::aic_wbreq_type wbReq,
	input wire aic_pkg::aic_wbrsp_type wbRsp,
	input wire logic moduleActive,
	input wire logic hartAck,
	input wire logic channelActive,
	input wire logic hartReq,
	input wire logic [1:0] hartCmd
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);
	////////////////////////////////////////////////////////////////////////
	ack_one_wait_a: assert property (wbReq.cyc && wbReq.stb && !wbRsp.ack
		|=> wbRsp.ack) else $error("ack not one cycle after request");
	ack_pulse_a: assert property (wbRsp.ack |=> !wbRsp.ack)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property (wbRsp.ack |-> $past(wbReq.cyc && wbReq.stb))
		else $error("ack without request");
	dat_idle_a: assert property (!wbRsp.ack |-> wbRsp.dat == 32'h0)
		else $error("read data outside ack");
	active_follow_a: assert property (!$past(srst) |->
		channelActive == $past(moduleActive))
		else $error("channel active not following module");
	hart_release_a: assert property (
		hartReq && hartAck |=> !hartReq)
		else $error("hart request held after answer");
	hart_hold_a: assert property (hartReq && !hartAck |=>
		!hartReq || $stable(hartCmd)) else $error("hart command moved");
	hart_step_a: assert property (hartReq && hartAck |=>
		hartCmd == ($past(hartCmd) == 2'h2 ? 2'h0 : $past(hartCmd) + 2'h1))
		else $error("hart command order wrong");
	hart_cmd_legal_a: assert property (hartCmd != 2'h3)
		else $error("hart command out of range");
	cover property (wbRsp.ack && !wbReq.we);
	cover property (hartReq && hartAck);
	cover property ($fell(hartReq) && !$past(hartAck));
endmodule

// >>> bench/aic_hart_model.sv
// hart engine model answering scan requests
`timescale 1ns/1ps
module aic_hart_model (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic hartReq,
	input wire logic [1:0] hartCmd,
	input wire logic slow,
	output logic hartAck,
	output logic [31:0] hartData
);
	logic [3:0] cnt;
	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge ref_clk)
	begin
		hartAck <= 1'b0;
		// data not qualified by ack toggles, so no stale word looks valid
		hartData <= ~hartData;
		if (srst)
		begin
			cnt <= 4'h0;
			hartData <= 32'h0;
		end
		else if (!hartReq || hartAck)
			cnt <= 4'h0;
		else if (cnt == (slow ? 4'h5 : 4'h1))
		begin
			hartAck <= 1'b1;
			hartData <= {16'h5ca0, 14'h0, hartCmd};
		end
		else
			cnt <= cnt + 4'h1;
	end
endmodule

// >>> bench/tb_top.sv
// testbench for the analog input channel
`timescale 1ns/1ps
module tb_top;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	aic_pkg::aic_wbreq_type wbReq = '0;
	aic_pkg::aic_wbrsp_type wbRsp;
	logic [15:0] measCurrent = 16'h0;
	logic measStrobe = 1'b1;
	logic moduleActive = 1'b0;
	logic hartSlow = 1'b0;
	logic activePrev = 1'b0;
	logic srstPrev = 1'b1;
	logic hartAck, procInvalid, faultShort, faultBreak, channelActive, hartReq;
	logic [31:0] hartData, rd;
	logic [15:0] procValue;
	logic [1:0] hartCmd;
	int n_mismatch = 0, n_tests = 0, seed = 51, cycles = 0, cur, k, w;
	int cs [8] = '{4000, 20000, 999, 1000, 21000, 21001, 24000, 30000};
	int sp [7] = '{-3000, -2500, 0, 2500, 10000, 12500, 13000};
	logic [15:0] rv [8] = '{aic_pkg::RST_SHORT, aic_pkg::RST_BREAK,
		aic_pkg::RST_LOWLIM, aic_pkg::RST_BEGPT, aic_pkg::RST_ENDPT,
		aic_pkg::RST_UPLIM, aic_pkg::RST_BEGCUR, aic_pkg::RST_ENDCUR};
	always #5 ref_clk = ~ref_clk;
	aic_channel i_dut (.ref_clk(ref_clk), .srst(srst), .wbReq(wbReq),
		.wbRsp(wbRsp), .measCurrent(measCurrent), .measStrobe(measStrobe),
		.moduleActive(moduleActive), .hartAck(hartAck), .hartData(hartData),
		.procValue(procValue), .procInvalid(procInvalid),
		.faultShort(faultShort), .faultBreak(faultBreak),
		.channelActive(channelActive), .hartReq(hartReq), .hartCmd(hartCmd));
	aic_hart_model i_hart (.ref_clk(ref_clk), .srst(srst), .hartReq(hartReq),
		.hartCmd(hartCmd), .slow(hartSlow), .hartAck(hartAck),
		.hartData(hartData));
	////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("counts: %0d compares, %0d mismatches", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		wbReq <= '{1'b1, 1'b1, w, a, 4'h3, {16'h0, d}};
		do @(posedge ref_clk); while (wbRsp.ack !== 1'b1 && n++ < 50);
		if (wbRsp.ack !== 1'b1)
			n_mismatch++;
		rd = wbRsp.dat;
		wbReq <= '0;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 16'h0);
		chk(rd, e);
	endtask
	task automatic meas(input int c);
		measCurrent <= c[15:0];
		repeat (3) @(posedge ref_clk);
	endtask
	task automatic outs(input logic [15:0] v, input logic i, s, b);
		chk({13'h0, procValue, procInvalid, faultShort, faultBreak},
			{13'h0, v, i, s, b});
	endtask
	// saturation order: lower first, upper wins if the limits cross
	function automatic logic [15:0] sat(input int v);
		if (v < 0)
			v = 0;
		if (v > 60000)
			v = 60000;
		return v[15:0];
	endfunction
	function automatic logic [15:0] pts(input int c);
		return sat(10000 + (c - 4000) * 40000 / 16000);
	endfunction
	function automatic logic [15:0] pct(input int p);
		p = p < -2500 ? -2500 : (p > 12500 ? 12500 : p);
		return sat(10000 + p * 40000 / 10000);
	endfunction
	////////////////////////////////////////////////////////////////////////
	always @(posedge ref_clk)
	begin
		if (!srstPrev)
			chk({31'h0, channelActive}, {31'h0, activePrev});
		activePrev <= moduleActive;
		srstPrev <= srst;
		moduleActive <= $random(seed);
		cycles++;
		if (cycles == 5000)
		begin
			n_mismatch++;
			stop_test();
		end
	end
	initial
	begin
		repeat (4) @(posedge ref_clk);
		srst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		outs(16'h0, 1'b0, 1'b0, 1'b1);
		rdchk(aic_pkg::ADR_CTRL, {25'h0, aic_pkg::RST_CTRL});
		for (k = 0; k < 8; k++)
			rdchk(aic_pkg::ADR_SHORT + {k[5:0], 2'b00},
				{16'h0, rv[k]});
		rdchk(8'h3c, 32'h0);
		$display("test reset done");
		for (k = 0; k < 28; k++)
		begin
			cur = k < 8 ? cs[k] : 1000 + {$random(seed)} % 20001;
			meas(cur);
			outs(pts(cur), 1'b0, cur > 21000,
				cur < 1000);
		end
		// strobe low: a new current must not reach the value
		measStrobe <= 1'b0;
		meas(4000);
		outs(pts(cur), 1'b0, 1'b0, 1'b0);
		measStrobe <= 1'b1;
		meas(cur);
		rdchk(aic_pkg::ADR_VALUE, {16'h0, pts(cur)});
		wb(1'b1, aic_pkg::ADR_VALUE, 16'h1234);
		rdchk(aic_pkg::ADR_VALUE, {16'h0, pts(cur)});
		chk({31'h0, hartReq}, 32'h0);
		$display("test normal done");
		// substitute differs from the later points, so a stuck value shows
		wb(1'b1, aic_pkg::ADR_SUB, 16'd2500);
		wb(1'b1, aic_pkg::ADR_CTRL, 16'h46);
		meas(500);
		outs(pct(2500), 1'b1, 1'b0, 1'b1);
		// active bit follows a random input, so it is masked here
		wb(1'b0, aic_pkg::ADR_STATUS, 16'h0);
		chk(rd & 32'hfffffff7, 32'h16);
		meas(12000);
		outs(pts(12000), 1'b0, 1'b0, 1'b0);
		wb(1'b1, aic_pkg::ADR_CTRL, 16'h4a);
		meas(500);
		outs(pts(12000), 1'b0, 1'b0, 1'b1);
		meas(25000);
		outs(pts(12000), 1'b0, 1'b1, 1'b0);
		// spare error mode code behaves as current value
		wb(1'b1, aic_pkg::ADR_CTRL, 16'h4e);
		repeat (2) @(posedge ref_clk);
		outs(pts(25000), 1'b0, 1'b1, 1'b0);
		$display("test error modes done");
		for (k = 0; k < 7; k++)
		begin
			w = sp[k];
			wb(1'b1, aic_pkg::ADR_SIM, w[15:0]);
			wb(1'b1, aic_pkg::ADR_CTRL, k[0] ? 16'h5b : 16'h4b);
			repeat (3) @(posedge ref_clk);
			outs(pct(sp[k]), k[0], 1'b1, 1'b0);
		end
		wb(1'b1, aic_pkg::ADR_CTRL, 16'h40);
		meas(500);
		outs(pts(500), 1'b0, 1'b0, 1'b0);
		$display("test simulation done");
		wb(1'b1, aic_pkg::ADR_CTRL, 16'h62);
		for (k = 0; k < 6; k++)
		begin
			hartSlow <= $random(seed);
			w = 0;
			do @(posedge ref_clk); while (!(hartReq === 1'b1 &&
				hartAck === 1'b1) && w++ < 50);
			if (!(hartReq === 1'b1 && hartAck === 1'b1))
				n_mismatch++;
		end
		// scan off right after an answer: an answer in the cut is dropped
		wb(1'b1, aic_pkg::ADR_CTRL, 16'h22);
		for (k = 0; k < 3; k++)
			rdchk(aic_pkg::ADR_SCAN0 + {k[5:0], 2'b00},
				{16'h5ca0, 14'h0, k[1:0]});
		repeat (2) @(posedge ref_clk);
		for (k = 0; k < 12; k++)
		begin
			@(posedge ref_clk);
			chk({31'h0, hartReq}, 32'h0);
		end
		$display("test hart done");
		stop_test();
	end
endmodule
bind aic_channel aic_channel_properties i_props (.ref_clk(ref_clk),
	.srst(srst), .wbReq(wbReq), .wbRsp(wbRsp), .moduleActive(moduleActive),
	.hartAck(hartAck), .channelActive(channelActive), .hartReq(hartReq),
	.hartCmd(hartCmd));
